// [rtl/wps_sequencer.sv]
/*
  Waveform playback sequencer: program and waveform stores, instruction
  execution with nested repeat and endless loops, scaled sample stream.
  Assumes the converter accepts one sample per clock while playing and
  host writes are synchronous to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wps_consts.svh"

// How it works
// - Waveform lengths count in whole granules of 16 samples.
// - One sample per clock, clock at the sample rate (default 2 GSa/s).
// - Output is stored sample times the range full-scale value.
// - Over-range results saturate at converter limits.
// - Play on output 1 drives the in-phase lane of channel 1.
// - A repeat block replays its body exactly its count, then moves on.
// - Endless loops replay forever, and loops nest.
// - Upload reports green on success, red on any load failure; an upload end in a write cycle leaves status none.
// - A single-run command after a green upload runs the last program once from the start.
module wps_sequencer
  import wps_pkg::*;
#(
  parameter int WAVE_DEPTH = `WPS_WAVE_DEPTH,
  parameter int PROG_DEPTH = `WPS_PROG_DEPTH,
  parameter int LOOP_DEPTH = `WPS_LOOP_DEPTH
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      progWrEn,
  input  wire logic [$clog2(PROG_DEPTH)-1:0] progWrAddr,
  input  wire wps_instr_t                progWrData,
  input  wire logic                      waveWrEn,
  input  wire logic [$clog2(WAVE_DEPTH)-1:0] waveWrAddr,
  input  wire logic [`WPS_SAMPLE_W-1:0]  waveWrData,
  input  wire logic                      uploadDone,
  input  wire logic                      uploadError,
  input  wire logic                      singleRun,
  input  wire logic [`WPS_RANGE_W-1:0]   fullScale,
  output wps_sample_t                    dacOut,
  output logic                           busy,
  output wps_status_t                    loadStatus,
  output logic                           badLength
);

  localparam int PAW = $clog2(PROG_DEPTH);
  localparam int WAW = $clog2(WAVE_DEPTH);
  localparam int LDW = $clog2(LOOP_DEPTH);
  localparam int GBITS = $clog2(`WPS_GRANULE);

  // Start field holds 10 granule bits, so deeper stores are unreachable
  if (WAVE_DEPTH % `WPS_GRANULE != 0 ||
      WAVE_DEPTH > (1 << (10 + GBITS))) begin : g_bad_wave
    $error("wps_sequencer: WAVE_DEPTH unusable");
  end
  if (LOOP_DEPTH < 2 || PROG_DEPTH < 2) begin : g_bad_depth
    $error("wps_sequencer: depths too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage

  wps_instr_t               progMem [PROG_DEPTH];
  logic [`WPS_SAMPLE_W-1:0] waveMem [WAVE_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (progWrEn)
      progMem[progWrAddr] <= progWrData;
  end

  always_ff @(posedge sys_clk) begin
    if (waveWrEn)
      waveMem[waveWrAddr] <= waveWrData;
  end

  ////////////////////////////////////////////////////////////////////////
  // Upload status

  logic failSeen_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      failSeen_r <= 1'b0;
      loadStatus <= WPS_STAT_NONE;
    end else if (progWrEn || waveWrEn) begin
      failSeen_r <= failSeen_r | uploadError;
      loadStatus <= WPS_STAT_NONE;
    end else if (uploadDone) begin
      failSeen_r <= 1'b0;
      loadStatus <= (failSeen_r || uploadError) ?
                    WPS_STAT_RED : WPS_STAT_GREEN;
    end else if (uploadError) begin
      failSeen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Loop stack

  wps_state_t         state_r;
  logic [PAW-1:0]     pc_r;
  logic [PAW-1:0]     loopPc_r  [LOOP_DEPTH];
  logic [15:0]        loopCnt_r [LOOP_DEPTH];
  logic               loopInf_r [LOOP_DEPTH];
  logic [LDW:0]       sp_r;
  logic [WAW-1:0]     rdAddr_r;
  logic [WAW-1:0]     endAddr_r;
  logic               playLane_r;
  wps_instr_t         cur;

  assign cur  = progMem[pc_r];
  assign busy = (state_r != WPS_ST_IDLE);

  // Granule count to sample address
  function automatic logic [WAW-1:0] granAddr(input logic [15:0] g);
    granAddr = WAW'({g, {GBITS{1'b0}}});
  endfunction : granAddr

  logic playLast;
  assign playLast = (state_r == WPS_ST_PLAY) && (rdAddr_r == endAddr_r);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r    <= WPS_ST_IDLE;
      pc_r       <= '0;
      sp_r       <= '0;
      rdAddr_r   <= '0;
      endAddr_r  <= '0;
      playLane_r <= 1'b0;
      badLength  <= 1'b0;
      for (int i = 0; i < LOOP_DEPTH; i++) begin
        loopPc_r[i]  <= '0;
        loopCnt_r[i] <= '0;
        loopInf_r[i] <= 1'b0;
      end
    end else begin
      unique case (state_r)
        WPS_ST_IDLE: begin
          if (singleRun && loadStatus == WPS_STAT_GREEN) begin
            pc_r      <= '0;
            sp_r      <= '0;
            badLength <= 1'b0;
            state_r   <= WPS_ST_FETCH;
          end
        end
        WPS_ST_FETCH, WPS_ST_PLAY: begin
          if (state_r == WPS_ST_FETCH || playLast) begin
            unique case (cur.op)
              WPS_OP_PLAY: begin
                // Short waves are the host's fault; flag them
                if (cur.arg < 16'(`WPS_MIN_LEN_PLAY / `WPS_GRANULE))
                  badLength <= 1'b1;
                rdAddr_r   <= granAddr({6'h00, cur.start});
                endAddr_r  <= granAddr({6'h00, cur.start} + cur.arg)
                              - WAW'(1);
                playLane_r <= (cur.output_sel == 2'h1);
                pc_r       <= pc_r + PAW'(1);
                state_r    <= WPS_ST_PLAY;
              end
              WPS_OP_REPEAT, WPS_OP_LOOP: begin
                if (cur.op == WPS_OP_REPEAT && cur.arg == 16'h0000) begin
                  pc_r    <= PAW'(cur.start); // Skip empty block
                  state_r <= WPS_ST_FETCH;
                end else if (sp_r < (LDW+1)'(LOOP_DEPTH)) begin
                  loopPc_r[sp_r[LDW-1:0]]  <= pc_r + PAW'(1);
                  loopCnt_r[sp_r[LDW-1:0]] <= cur.arg;
                  loopInf_r[sp_r[LDW-1:0]] <= (cur.op == WPS_OP_LOOP);
                  sp_r    <= sp_r + (LDW+1)'(1);
                  pc_r    <= pc_r + PAW'(1);
                  state_r <= WPS_ST_FETCH;
                end else begin
                  state_r <= WPS_ST_IDLE; // Nesting overflow stops run
                end
              end
              WPS_OP_CLOSE: begin
                if (sp_r == '0) begin
                  state_r <= WPS_ST_IDLE;
                end else if (loopInf_r[sp_r[LDW-1:0] - LDW'(1)]) begin
                  pc_r    <= loopPc_r[sp_r[LDW-1:0] - LDW'(1)];
                  state_r <= WPS_ST_FETCH;
                end else if (loopCnt_r[sp_r[LDW-1:0] - LDW'(1)] > 16'h0001)
                begin
                  loopCnt_r[sp_r[LDW-1:0] - LDW'(1)] <=
                    loopCnt_r[sp_r[LDW-1:0] - LDW'(1)] - 16'h0001;
                  pc_r    <= loopPc_r[sp_r[LDW-1:0] - LDW'(1)];
                  state_r <= WPS_ST_FETCH;
                end else begin
                  sp_r    <= sp_r - (LDW+1)'(1);
                  pc_r    <= pc_r + PAW'(1);
                  state_r <= WPS_ST_FETCH;
                end
              end
              default: state_r <= WPS_ST_IDLE; // End or illegal code
            endcase
          end else begin
            rdAddr_r <= rdAddr_r + WAW'(1);
          end
        end
        default: state_r <= WPS_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stream

  logic [`WPS_SAMPLE_W-1:0] scaled;

  wps_scaler #(
    .W (`WPS_SAMPLE_W)
  ) u_scaler (
    .sampleIn  (waveMem[rdAddr_r]),
    .fullScale (fullScale),
    .sampleOut (scaled)
  );

  // Control ops between plays cost cycles; back to back only for plays
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dacOut <= '0;
    end else begin
      dacOut.valid   <= (state_r == WPS_ST_PLAY);
      dacOut.inPhase <= (state_r == WPS_ST_PLAY && playLane_r) ?
                        scaled : '0;
      dacOut.quad    <= (state_r == WPS_ST_PLAY && !playLane_r) ?
                        scaled : '0;
    end
  end

endmodule : wps_sequencer
`default_nettype wire

// [rtl/wps_consts.svh]
/*
  Constants of the waveform playback sequencer: sizes, widths, rate, limits.
  Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef WPS_CONSTS_SVH
`define WPS_CONSTS_SVH

`define WPS_GRANULE        16
`define WPS_MIN_LEN_PLAY   32
`define WPS_MIN_LEN_TABLE  16
`define WPS_SAMPLE_W       16
`define WPS_RANGE_W        16
`define WPS_WAVE_DEPTH     1024
`define WPS_PROG_DEPTH     64
`define WPS_LOOP_DEPTH     4
`define WPS_CNT_W          16
`define WPS_RATE_MSPS      2000

`endif

// [rtl/wps_pkg.sv]
/*
  Types of the waveform playback sequencer.
  Assumes wps_consts.svh is on the include path.
*/
`include "wps_consts.svh"

package wps_pkg;

  typedef enum logic [2:0] {
    WPS_OP_END    = 3'b000,
    WPS_OP_PLAY   = 3'b001,
    WPS_OP_REPEAT = 3'b010,
    WPS_OP_LOOP   = 3'b011,
    WPS_OP_CLOSE  = 3'b100
  } wps_op_t;

  // Instruction word: play start/length in granules, or repeat count
  typedef struct packed {
    wps_op_t     op;
    logic [1:0]  output_sel;
    logic [9:0]  start;
    logic [15:0] arg;
  } wps_instr_t;

  typedef struct packed {
    logic                      valid;
    logic [`WPS_SAMPLE_W-1:0]  inPhase;
    logic [`WPS_SAMPLE_W-1:0]  quad;
  } wps_sample_t;

  typedef enum logic [1:0] {
    WPS_ST_IDLE = 2'b00,
    WPS_ST_FETCH = 2'b01,
    WPS_ST_PLAY = 2'b10
  } wps_state_t;

  typedef enum logic [1:0] {
    WPS_STAT_NONE  = 2'b00,
    WPS_STAT_GREEN = 2'b01,
    WPS_STAT_RED   = 2'b10
  } wps_status_t;

endpackage : wps_pkg

// [rtl/wps_scaler.sv]
/*
  Scales one stored sample by the full-scale setting and saturates.
  Assumes signed Q1.15 samples and an unsigned Q1.15 scale; pure logic.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wps_consts.svh"

module wps_scaler
  import wps_pkg::*;
#(
  parameter int W = `WPS_SAMPLE_W
) (
  input  wire logic [W-1:0] sampleIn,
  input  wire logic [W-1:0] fullScale,
  output logic      [W-1:0] sampleOut
);

  logic signed [2*W:0] prod;
  logic signed [2*W:0] shifted;
  localparam logic signed [2*W:0] MaxV = (2*W+1)'((1 << (W-1)) - 1);
  localparam logic signed [2*W:0] MinV = -(2*W+1)'(1 << (W-1));

  if (W < 2) begin : g_bad_w
    $error("wps_scaler: W too small");
  end

  always_comb begin
    prod      = $signed({{(W+1){sampleIn[W-1]}}, sampleIn})
              * $signed({{(W+1){1'b0}}, fullScale});
    shifted   = prod >>> (W-1);
    // Clip instead of wrap, as the converter would
    if (shifted > MaxV)
      sampleOut = MaxV[W-1:0];
    else if (shifted < MinV)
      sampleOut = MinV[W-1:0];
    else
      sampleOut = shifted[W-1:0];
  end

endmodule : wps_scaler
`default_nettype wire

// [tb/wps_checker.sv]
/* Port checker for wps_sequencer.
   Assumes the bind below and one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module wps_checker
  import wps_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        progWrEn,
  input wire logic        waveWrEn,
  input wire logic        uploadDone,
  input wire logic        uploadError,
  input wire logic        singleRun,
  input wire wps_sample_t dacOut,
  input wire logic        busy,
  input wire wps_status_t loadStatus,
  input wire logic        badLength
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  // Failure memory since the last upload end; writes keep it
  logic errSeen_r;
  logic wantRed;
  assign wantRed = errSeen_r || uploadError;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) errSeen_r <= 1'h0;
    else if (uploadDone && !progWrEn && !waveWrEn) errSeen_r <= 1'h0;
    else if (uploadError) errSeen_r <= 1'h1;
  end
  ////////////////////////////////////////////////////////////////////
  a_upload_status: assert property (uploadDone |=> loadStatus ==
    ($past(wantRed) ? WPS_STAT_RED : WPS_STAT_GREEN))
    else $error("upload status wrong");
  a_write_clears: assert property ((progWrEn || waveWrEn)
    && !uploadDone |=> loadStatus == WPS_STAT_NONE)
    else $error("write kept status");
  a_red_holds: assert property (loadStatus == WPS_STAT_RED
    && !progWrEn && !waveWrEn && !uploadDone |=> $stable(loadStatus))
    else $error("red status lost");
  a_run_start: assert property (singleRun && !busy
    && loadStatus == WPS_STAT_GREEN |=> busy)
    else $error("run not started");
  a_run_refused: assert property (singleRun && !busy
    && loadStatus != WPS_STAT_GREEN |=> !busy)
    else $error("run without green");
  a_valid_busy: assert property (dacOut.valid |-> $past(busy))
    else $error("sample outside run");
  a_idle_quiet: assert property (!busy ##1 !busy |-> !dacOut.valid)
    else $error("sample while idle");
  a_bad_sticky: assert property (badLength && busy |=> badLength)
    else $error("length flag dropped");
endmodule : wps_checker
bind wps_sequencer wps_checker i_wps_checker (.sys_clk, .rst,
  .progWrEn, .waveWrEn, .uploadDone, .uploadError, .singleRun,
  .dacOut, .busy, .loadStatus, .badLength);
`default_nettype wire

// [tb/wps_dac_model.sv]
/* Converter model: takes one sample per valid clock.
   Assumes dacOut is registered in sys_clk. */
`timescale 1ns/1ns
`default_nettype none
module wps_dac_model
  import wps_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire wps_sample_t dacOut,
  output int               sampleCnt,
  output int               runCnt,
  output logic [15:0]      lastI,
  output logic [15:0]      lastQ
);
  logic prevV;
  // Runs counted so idle gaps between plays show up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prevV <= 1'h0;
      sampleCnt <= 0;
      runCnt <= 0;
      lastI <= 16'h0;
      lastQ <= 16'h0;
    end else begin
      prevV <= dacOut.valid;
      if (dacOut.valid) begin
        sampleCnt <= sampleCnt + 1;
        lastI <= dacOut.inPhase;
        lastQ <= dacOut.quad;
        if (!prevV) runCnt <= runCnt + 1;
      end
    end
  end
endmodule : wps_dac_model
`default_nettype wire

// [tb/waveform_playback_sequencer_bench.sv]
/* Scenario bench for wps_sequencer with converter model.
   Assumes default depths and Q1.15 scale. */
`timescale 1ns/1ns
`default_nettype none
module waveform_playback_sequencer_bench
  import wps_pkg::*;
;
  logic        sys_clk, rst, progWrEn, waveWrEn, uploadDone;
  logic        uploadError, singleRun, busy, badLength;
  logic [5:0]  progWrAddr;
  logic [9:0]  waveWrAddr;
  logic [15:0] waveWrData, fullScale, lastI, lastQ;
  wps_instr_t  progWrData;
  wps_sample_t dacOut;
  wps_status_t loadStatus;
  int          sampleCnt, runCnt, mismatches, n_compared, cyc;
  bit          errPend;
  wps_sequencer i_wps_sequencer (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .progWrEn    (progWrEn),
    .progWrAddr  (progWrAddr),
    .progWrData  (progWrData),
    .waveWrEn    (waveWrEn),
    .waveWrAddr  (waveWrAddr),
    .waveWrData  (waveWrData),
    .uploadDone  (uploadDone),
    .uploadError (uploadError),
    .singleRun   (singleRun),
    .fullScale   (fullScale),
    .dacOut      (dacOut),
    .busy        (busy),
    .loadStatus  (loadStatus),
    .badLength   (badLength)
  );
  wps_dac_model i_wps_dac_model (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .dacOut    (dacOut),
    .sampleCnt (sampleCnt),
    .runCnt    (runCnt),
    .lastI     (lastI),
    .lastQ     (lastQ)
  );
  initial begin sys_clk = 0; forever #50 sys_clk = ~sys_clk; end
  ////////////////////////////////////////////////////////////////////
  task ck(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task p(input logic [5:0] a, input wps_op_t o, input int q,
         input int s, input int n);
    @(posedge sys_clk);
    progWrEn <= 1; progWrAddr <= a;
    progWrData <= {o, 2'(q), 10'(s), 16'(n)};
    @(posedge sys_clk);
    progWrEn <= 0;
  endtask : p
  task fw(input logic [9:0] b, input logic [15:0] v);
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk);
      waveWrEn <= 1; waveWrAddr <= b + 10'(i); waveWrData <= v;
    end
    @(posedge sys_clk);
    waveWrEn <= 0;
  endtask : fw
  task up(input int e);
    logic red;
    red = (e != 0) || errPend;
    @(posedge sys_clk);
    uploadDone <= 1; uploadError <= (e != 0);
    @(posedge sys_clk);
    uploadDone <= 0; uploadError <= 0;
    #1 ck(loadStatus, red ? WPS_STAT_RED : WPS_STAT_GREEN);
    errPend = 1'b0;
  endtask : up
  // Lone load failure; must survive later writes
  task er;
    @(posedge sys_clk);
    uploadError <= 1'b1;
    @(posedge sys_clk);
    uploadError <= 1'b0;
    errPend = 1'b1;
  endtask : er
  task go;
    @(posedge sys_clk); singleRun <= 1;
    @(posedge sys_clk); singleRun <= 0;
    #1;
  endtask : go
  task rn(output int n);
    go();
    // Bounded wait on busy
    for (n = 0; busy === 1'h1 && n < 2000; n++) @(posedge sys_clk) #1;
    ck(n < 2000, 1);
    @(posedge sys_clk) #1;
  endtask : rn
  ////////////////////////////////////////////////////////////////////
  task t_walk;
    int c, r, n;
    p(6'h0, WPS_OP_PLAY, 2'h1, 10'h0, 16'h2); p(6'h1, WPS_OP_END, 0, 0, 0);
    up(0); c = sampleCnt; r = runCnt; rn(n);
    ck(n, 33);
    ck(sampleCnt - c, 32);
    ck(runCnt - r, 1);
    ck(lastI, 16'h1234);
    ck(badLength, 0);
    $display("walk done");
  endtask : t_walk
  task t_rep;
    int c, n;
    p(6'h0, WPS_OP_REPEAT, 0, 10'h3, 16'h3);
    p(6'h1, WPS_OP_PLAY, 0, 10'h0, 16'h2);
    p(6'h2, WPS_OP_CLOSE, 0, 0, 0); p(6'h3, WPS_OP_END, 0, 0, 0);
    up(0); c = sampleCnt; rn(n);
    ck(sampleCnt - c, 96);
    ck(lastQ, 16'h1234);
    $display("repeat done");
  endtask : t_rep
  task t_b2b;
    int c, r, n;
    @(posedge sys_clk) fullScale <= 16'hffff;
    p(6'h0, WPS_OP_PLAY, 2'h1, 10'h0, 16'h2);
    p(6'h1, WPS_OP_PLAY, 2'h1, 10'h2, 16'h2);
    p(6'h2, WPS_OP_END, 0, 0, 0);
    up(0); c = sampleCnt; r = runCnt; rn(n);
    ck(n, 65);
    ck(sampleCnt - c, 64);
    ck(runCnt - r, 1);
    ck(lastI, 16'h7fff);
    @(posedge sys_clk) fullScale <= 16'h8000;
    $display("back to back done");
  endtask : t_b2b
  task t_red;
    int c, n;
    p(6'h0, WPS_OP_PLAY, 2'h1, 10'h0, 16'h1); p(6'h1, WPS_OP_END, 0, 0, 0);
    up(1); go();
    ck(busy, 0);
    // Failure ahead of the last write must still show red
    er(); p(6'h1, WPS_OP_END, 0, 0, 0);
    up(0); go();
    ck(busy, 0);
    p(6'h1, WPS_OP_END, 0, 0, 0);
    up(0); c = sampleCnt; rn(n);
    ck(badLength, 1);
    ck(sampleCnt - c, 16);
    $display("red and short done");
  endtask : t_red
  task t_nest;
    int c;
    p(6'h0, WPS_OP_LOOP, 0, 0, 0); p(6'h1, WPS_OP_REPEAT, 0, 10'h4, 16'h2);
    p(6'h2, WPS_OP_PLAY, 2'h1, 10'h0, 16'h2);
    p(6'h3, WPS_OP_CLOSE, 0, 0, 0); p(6'h4, WPS_OP_CLOSE, 0, 0, 0);
    p(6'h5, WPS_OP_END, 0, 0, 0);
    up(0); c = sampleCnt; go();
    repeat (400) @(posedge sys_clk);
    #1 ck(busy, 1);
    ck(sampleCnt - c > 250, 1);
    // Only a reset ends an endless loop
    @(posedge sys_clk) rst <= 1;
    @(posedge sys_clk) rst <= 0;
    #1 ck(busy, 0);
    ck(loadStatus, WPS_STAT_NONE);
    $display("nested loop done");
  endtask : t_nest
  ////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      final_report();
    end
  end
  initial begin
    {rst, progWrEn, waveWrEn, uploadDone, uploadError, singleRun} = 6'h20;
    {progWrAddr, waveWrAddr, waveWrData, progWrData} = 0;
    fullScale = 16'h8000;
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    fw(10'h0, 16'h1234); fw(10'h20, 16'h7000);
    t_walk(); t_rep(); t_b2b(); t_red(); t_nest();
    final_report();
  end
endmodule : waveform_playback_sequencer_bench
`default_nettype wire
